/* File: rtl/cil_config_loader.sv */
// configuration clear, init handshake, bitstream parse and start-up sequencer
`timescale 1ns/10ps
module cil_config_loader #(
	parameter int MASTER_WAIT_CYC = cil_pkg::MASTER_MAX_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// configuration pins
	input wire logic programReqN,
	input wire logic initIn,
	output logic initOe,
	input wire logic doneIn,
	output logic doneOe,
	input wire logic [2:0] modeSel,
	output logic modePullupEn,
	input wire logic cfgClkIn,
	output logic cfgClkOut,
	output logic cfgClkOe,
	input wire logic dataIn,
	output logic dataOut,
	output logic [cil_pkg::ADDR_W-1:0] promAddr,
	// status pins
	output logic highDuringConfig,
	output logic lowDuringConfigN,
	// start-up options and user nets
	input wire cil_pkg::cil_opts_s opts,
	input wire logic userWakeupClock,
	output logic ioActive,
	output logic gsrActive,
	// mode pins as user pads
	input wire logic [2:0] modePadPlaced,
	input wire logic modeMiddleUserData,
	output logic modeUpperUserPad,
	output logic modeLowerUserPad,
	output logic modeMiddleUserPad,
	output logic modeMiddleOe,
	// frame data toward configuration memory
	output cil_pkg::cil_wr_s cfgWr
);
	import cil_pkg::*;

	typedef enum {
		ST_CLEAR, ST_LASTCLR, ST_INITWAIT, ST_MWAIT, ST_MSAMP,
		ST_PRE, ST_LEN, ST_FRAME, ST_PASS, ST_ERR
	} cil_state_e;

	cil_state_e state_r, state_nxt;
	logic [NPIN-1:0] syncA_r, syncB_r, syncC_r;
	logic [7:0] porCnt_r;
	logic [7:0] frmAddr_r;
	logic [15:0] waitCnt_r;
	logic [LEN_W-1:0] cfgCnt_r, length_r;
	logic [2:0] preSh_r;
	logic [7:0] bitCnt_r, frmIdx_r;
	logic [2:0] mode_r;
	logic master_r, addrDown_r, fast_r;
	logic [7:0] divCnt_r;
	logic [NSTAGE-1:0] stage_r;
	logic [2:0] byteCnt_r;

	// pin synchronisers: lane A is read only by lane B
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			syncA_r <= '1;
			syncB_r <= '1;
			syncC_r <= '1;
		end else begin
			syncA_r <= {modeSel, userWakeupClock, cfgClkIn, dataIn, doneIn, initIn, programReqN};
			syncB_r <= syncA_r;
			syncC_r <= syncB_r;
		end
	end

	wire progLow = !syncB_r[PIN_PROG];
	wire initHigh = syncB_r[PIN_INIT];
	wire doneHigh = syncB_r[PIN_DONE];
	wire dinBit = syncB_r[PIN_DIN];
	wire [2:0] modeNow = syncB_r[PIN_M0 +: 3];
	wire slvRise = syncB_r[PIN_CONFIGURATION_CLOCK] && !syncC_r[PIN_CONFIGURATION_CLOCK];
	wire usrRise = syncB_r[PIN_UCLK] && !syncC_r[PIN_UCLK];

	wire porBusy = porCnt_r != 8'(POR_CYC);
	wire passEnd = frmAddr_r == 8'(CLR_FRAMES - 1);
	wire modeMaster = (modeNow == MODE_MPAR_UP) || (modeNow == MODE_MPAR_DN);
	wire loading = (state_r == ST_MSAMP) || (state_r == ST_PRE) || (state_r == ST_LEN)
		|| (state_r == ST_FRAME) || (state_r == ST_PASS);

	// master clock divider; fast rate is the slow rate times eight
	wire [7:0] halfPer = fast_r ? 8'(SLOW_HALF / FAST_DIV) : 8'(SLOW_HALF); // [RQ12]
	wire clkRun = master_r && loading && !stage_r[NSTAGE-1];
	wire divWrap = divCnt_r == halfPer - 8'h01;
	wire mstRise = clkRun && divWrap && !cfgClkOut;
	wire cfgRise = master_r ? mstRise : slvRise;

	// frame field positions
	wire [7:0] endStart = 8'(1 + FRAME_DATA);
	wire [7:0] frmLast = 8'(FRAME_DATA + FRAME_END_W);
	wire inData = (bitCnt_r != 8'h00) && (bitCnt_r < endStart);
	wire [7:0] endIdx = bitCnt_r - endStart;
	wire endExp = FRAME_END[FRAME_END_W - 1 - 32'(endIdx[1:0])];
	wire bitBad = (bitCnt_r == 8'h00) ? dinBit : (!inData && (dinBit != endExp)); // [RQ13]
	wire lastFrame = frmIdx_r == 8'(NUM_FRAMES - 1);
	wire lenHit = cfgCnt_r == length_r; // [RQ19]

	// start-up stage stepping and event selection
	wire stgClk = opts.userClk ? usrRise : cfgRise; // [RQ20] [RQ22]
	wire stg3In = stage_r[DONE_IN_STAGE-1] && (!opts.doneSync || doneHigh); // [RQ21]
	// bit 0 is never taken from here; it is set by the length match alone
	wire [NSTAGE-1:0] stageNext = {stage_r[NSTAGE-2:DONE_IN_STAGE], stg3In,
		stage_r[DONE_IN_STAGE-2:0], 1'b0};
	wire doneRel = stage_r[3'(opts.doneStage) + 3'h1]; // [RQ17] [RQ18]
	wire ioRel = stage_r[3'(opts.ioStage) + 3'h1]; // [RQ17] [RQ18]
	wire gsrRel = stage_r[3'(opts.gsrStage) + 3'h1]; // [RQ17] [RQ18]

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_CLEAR: if (passEnd && !porBusy && !progLow) state_nxt = ST_LASTCLR; // [RQ5]
			ST_LASTCLR: if (passEnd) state_nxt = ST_INITWAIT; // [RQ7]
			ST_INITWAIT: if (initHigh) state_nxt = modeMaster ? ST_MWAIT : ST_MSAMP; // [RQ16]
			ST_MWAIT: if (waitCnt_r == 16'(MASTER_WAIT_CYC - 1)) state_nxt = ST_MSAMP; // [RQ7]
			ST_MSAMP: if (waitCnt_r == 16'(SAMPLE_DLY - 1)) state_nxt = ST_PRE; // [RQ8]
			ST_PRE: if (cfgRise && {preSh_r, dinBit} == PREAMBLE) state_nxt = ST_LEN; // [RQ9]
			ST_LEN: if (cfgRise && bitCnt_r == 8'(LEN_W - 1)) state_nxt = ST_FRAME;
			ST_FRAME: begin
				if (cfgRise && bitBad) begin
					state_nxt = ST_ERR; // [RQ13]
				end else if (cfgRise && bitCnt_r == frmLast && lastFrame) begin
					state_nxt = ST_PASS;
				end
			end
			ST_PASS: state_nxt = ST_PASS;
			ST_ERR: state_nxt = ST_ERR;
			default: state_nxt = ST_CLEAR;
		endcase
		if (porBusy || progLow) state_nxt = ST_CLEAR; // [RQ4] [RQ14]
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r <= ST_CLEAR;
			porCnt_r <= '0;
			frmAddr_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (porBusy) porCnt_r <= porCnt_r + 8'h01;
			// memory cleared one frame per clock in turn
			if (state_r == ST_CLEAR || state_r == ST_LASTCLR) begin
				frmAddr_r <= passEnd ? 8'h00 : frmAddr_r + 8'h01; // [RQ4]
			end else begin
				frmAddr_r <= '0;
			end
		end
	end

	// wait timer, clearing on every state change
	always_ff @(posedge mclk) begin
		if (!nrst || state_nxt != state_r) begin
			waitCnt_r <= '0;
		end else begin
			waitCnt_r <= waitCnt_r + 16'h0001;
		end
	end

	// mode capture and master flag
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mode_r <= MODE_SLAVE_SER;
			master_r <= 1'b0;
			addrDown_r <= 1'b0;
		end else if (state_r == ST_MSAMP && state_nxt == ST_PRE) begin
			mode_r <= modeNow; // [RQ1] [RQ8]
			master_r <= modeMaster; // [RQ23]
			addrDown_r <= modeNow == MODE_MPAR_DN; // [RQ23]
		end else if (state_r == ST_CLEAR) begin
			master_r <= 1'b0;
		end
	end

	// clock count since init went high; length compares against it
	always_ff @(posedge mclk) begin
		if (!nrst || (state_r == ST_INITWAIT && initHigh)) begin
			cfgCnt_r <= '0; // [RQ24]
		end else if (cfgRise && loading && cfgCnt_r != '1) begin
			cfgCnt_r <= cfgCnt_r + 24'h000001;
		end
	end

	// bitstream parser
	always_ff @(posedge mclk) begin
		if (!nrst || state_r == ST_CLEAR) begin
			preSh_r <= '1;
			length_r <= '1;
			bitCnt_r <= '0;
			frmIdx_r <= '0;
			fast_r <= 1'b0;
		end else if (cfgRise) begin
			preSh_r <= {preSh_r[1:0], dinBit};
			case (state_r)
				ST_PRE: bitCnt_r <= '0;
				ST_LEN: begin
					length_r <= {length_r[LEN_W-2:0], dinBit}; // [RQ9]
					bitCnt_r <= (bitCnt_r == 8'(LEN_W - 1)) ? 8'h00 : bitCnt_r + 8'h01;
				end
				ST_FRAME: begin
					if (frmIdx_r == 8'h00 && bitCnt_r == 8'(FAST_BIT_POS) && master_r) begin
						fast_r <= dinBit; // [RQ12]
					end
					if (bitCnt_r == frmLast) begin
						bitCnt_r <= '0;
						frmIdx_r <= frmIdx_r + 8'h01;
					end else begin
						bitCnt_r <= bitCnt_r + 8'h01; // [RQ13]
					end
				end
				default: bitCnt_r <= bitCnt_r;
			endcase
		end
	end

	// master clock generator and its divider
	always_ff @(posedge mclk) begin
		if (!nrst || !clkRun) begin
			divCnt_r <= '0;
			cfgClkOut <= 1'b0;
		end else if (divWrap) begin
			divCnt_r <= '0;
			cfgClkOut <= !cfgClkOut;
		end else begin
			divCnt_r <= divCnt_r + 8'h01;
		end
	end

	// address steps once per eight configuration clocks, one byte
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			promAddr <= ADDR_UP_START;
			byteCnt_r <= '0;
		end else if (state_r == ST_MSAMP) begin
			promAddr <= (modeNow == MODE_MPAR_DN) ? ADDR_DN_START : ADDR_UP_START; // [RQ23]
			byteCnt_r <= '0;
		end else if (mstRise) begin
			byteCnt_r <= byteCnt_r + 3'h1;
			if (byteCnt_r == 3'h7) begin
				promAddr <= addrDown_r ? promAddr - 18'h00001 : promAddr + 18'h00001;
			end
		end
	end

	// start-up shift register
	always_ff @(posedge mclk) begin
		if (!nrst || state_r != ST_PASS) begin
			stage_r <= '0;
		end else begin
			if (cfgRise && lenHit) stage_r[0] <= 1'b1; // [RQ19]
			if (stgClk) stage_r[NSTAGE-1:1] <= stageNext[NSTAGE-1:1]; // [RQ20]
		end
	end

	// registered pins and status
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			initOe <= 1'b1; // [RQ6]
			doneOe <= 1'b1;
			highDuringConfig <= 1'b1;
			lowDuringConfigN <= 1'b0;
			dataOut <= 1'b1;
			cfgClkOe <= 1'b0;
			ioActive <= 1'b0;
			gsrActive <= 1'b1;
			modePullupEn <= 1'b1;
			cfgWr <= '0;
		end else begin
			// forced low while clearing, on program request or on frame error
			initOe <= progLow || state_nxt == ST_CLEAR || state_nxt == ST_LASTCLR
				|| state_nxt == ST_ERR; // [RQ7] [RQ13] [RQ15]
			doneOe <= !doneRel;
			highDuringConfig <= !ioRel; // [RQ6]
			lowDuringConfigN <= ioRel; // [RQ6]
			ioActive <= ioRel; // [RQ22]
			gsrActive <= !gsrRel;
			modePullupEn <= !ioRel; // [RQ2]
			cfgClkOe <= clkRun;
			cfgWr.strobe <= cfgRise && state_r == ST_FRAME && inData;
			cfgWr.bitVal <= dinBit;
			if (cfgRise) begin
				// chain sees preamble and length, never our frame start bits
				dataOut <= (state_r == ST_FRAME) ? 1'b1 : dinBit; // [RQ11]
			end
		end
	end

	// mode pins as user pads; upper/lower inputs and middle enable only once placed and I/O active, middle data passed through always
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			modeUpperUserPad <= 1'b0;
			modeLowerUserPad <= 1'b0;
			modeMiddleUserPad <= 1'b0;
			modeMiddleOe <= 1'b0;
		end else begin
			modeUpperUserPad <= ioRel && modePadPlaced[2] && modeNow[2]; // [RQ3]
			modeLowerUserPad <= ioRel && modePadPlaced[0] && modeNow[0]; // [RQ3]
			modeMiddleUserPad <= modeMiddleUserData;
			modeMiddleOe <= ioRel && modePadPlaced[1]; // [RQ3]
		end
	end
endmodule // cil_config_loader

/* File: rtl/cil_pkg.sv */
// constants and carrier types for the configuration loader and start-up sequencer
// How it works
// RQ1 - mode pins are sampled before configuration and select the configuration mode
// RQ2 - mode pins get weak pull-ups during configuration; open pins mean slave serial
// RQ3 - after configuration upper/lower mode pins are user inputs, middle a user output
// RQ4 - power-on delay or program request holds memory clear, frames cleared in turn
// RQ5 - each clear pass end tests delay and program; if idle one more pass, then init
// RQ6 - from power-up low-during-config, init, done are low and high-during-config high
// RQ7 - init released after last pass; master waits 50 to 250 us first
// RQ8 - two clocks after init seen high, mode pins sampled and interface activated
// RQ9 - preamble 0010 precedes a 24-bit length count of configuration clocks
// RQ10 - clock source gives four clocks beyond the length count
// RQ11 - serial out passes preamble and length, held high in frames, then follows input
// RQ12 - master runs slow clock until an early first-frame bit raises it eightfold
// RQ13 - frames are start, data, error fields; an error halts loading, init pulled low
// RQ14 - while program low clearing repeats; on release one more clear, then configure
// RQ15 - program low forces init low; program pin has a permanent weak pull-up
// RQ16 - init held low externally makes device wait; master then waits up to 250 us
// RQ17 - start-up events done, I/O active, set/reset release have selectable order
// RQ18 - default: done first, I/O one clock later, set/reset one clock after that
// RQ19 - start-up begins when memory full and clock count equals length; stage one set
// RQ20 - later start-up stages clocked by configuration clock or user wake-up clock
// RQ21 - done-synchronised options feed wire-ANDed done into the fourth stage
// RQ22 - first four stages time the events (here stages two to five); missing user clock leaves outputs inactive
// RQ23 - mode 111 slave serial, 100 master parallel up, 110 master parallel down
// RQ24 - length comparison counter cleared when init seen high, at least 24 bits
package cil_pkg;
	localparam int CLK_MHZ = 20;
	localparam int INIT_MIN_US = 50;
	localparam int INIT_MIN_CYC = INIT_MIN_US * CLK_MHZ;
	localparam int MASTER_MAX_US = 250;
	localparam int MASTER_MAX_CYC = MASTER_MAX_US * CLK_MHZ;
	localparam int POR_CYC = 64;
	localparam int CLR_FRAMES = 16;
	localparam int SAMPLE_DLY = 2;
	localparam int LEN_W = 24;
	localparam logic [3:0] PREAMBLE = 4'h2;
	localparam int FRAME_DATA = 32;
	localparam int FRAME_END_W = 4;
	localparam logic [FRAME_END_W-1:0] FRAME_END = 4'h7;
	localparam int NUM_FRAMES = 4;
	localparam int FAST_BIT_POS = 1;
	localparam int SLOW_HALF = 16;
	localparam int FAST_DIV = 8;
	localparam int ADDR_W = 18;
	localparam logic [ADDR_W-1:0] ADDR_UP_START = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_DN_START = 18'h3FFFF;
	localparam logic [2:0] MODE_SLAVE_SER = 3'h7;
	localparam logic [2:0] MODE_MPAR_UP = 3'h4;
	localparam logic [2:0] MODE_MPAR_DN = 3'h6;
	localparam int NSTAGE = 5;
	localparam logic [1:0] DFLT_DONE_STG = 2'h0;
	localparam logic [1:0] DFLT_IO_STG = 2'h1;
	localparam logic [1:0] DFLT_GSR_STG = 2'h2;
	localparam int DONE_IN_STAGE = 3;
	// synchroniser lanes
	localparam int PIN_PROG = 0;
	localparam int PIN_INIT = 1;
	localparam int PIN_DONE = 2;
	localparam int PIN_DIN = 3;
	localparam int PIN_CONFIGURATION_CLOCK = 4;
	localparam int PIN_UCLK = 5;
	localparam int PIN_M0 = 6;
	localparam int NPIN = 9;
	typedef struct packed {
		logic userClk;
		logic doneSync;
		logic [1:0] doneStage;
		logic [1:0] ioStage;
		logic [1:0] gsrStage;
	} cil_opts_s;
	typedef struct packed {
		logic strobe;
		logic bitVal;
	} cil_wr_s;
endpackage

/* File: verification/cil_cfg_source.sv */
// serial configuration source model
`timescale 1ns/10ps
module cil_cfg_source #(
	parameter int HALF = 4
) (
	// clock
	input wire logic mclk,
	// link
	input wire logic initWire,
	output logic cfgClk,
	output logic cfgData
);
	import cil_pkg::*;
	localparam int LEN = 8 + LEN_W + NUM_FRAMES * (1 + FRAME_DATA + FRAME_END_W);
	initial begin
		cfgClk = 1'h0;
		cfgData = 1'h1;
	end
	// clock stands low between bits of a transfer and after it
	task automatic bitOut(input logic b);
		cfgData <= b;
		repeat (HALF) @(posedge mclk);
		cfgClk <= 1'h1;
		repeat (HALF) @(posedge mclk);
		cfgClk <= 1'h0;
	endtask
	task automatic send(input logic bad);
		logic [31:0] hdr;
		int i;
		int f;
		hdr = {8'hF2, 24'(LEN)};
		while (initWire !== 1'h1) @(posedge mclk);
		repeat (16) @(posedge mclk);
		for (i = 31; i >= 0; i--) bitOut(hdr[i]);
		for (f = 0; f < NUM_FRAMES; f++) begin
			bitOut(1'h0);
			for (i = FRAME_DATA - 1; i >= 0; i--) bitOut(i[0] ^ f[1]);
			for (i = FRAME_END_W - 1; i >= 0; i--) bitOut(FRAME_END[i] ^ (bad && i == 0));
		end
		repeat (4) bitOut(1'h1);
		// released line must not keep the last bit
		cfgData <= ~cfgData;
	endtask
endmodule // cil_cfg_source

/* File: verification/cil_config_loader_properties.sv */
// port assertions for the configuration loader
`timescale 1ns/10ps
module cil_props (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// pins
	input wire logic programReqN,
	input wire logic [2:0] modeSel,
	input wire logic initOe,
	input wire logic doneOe,
	input wire logic cfgClkOe,
	input wire logic dataOut,
	input wire logic highDuringConfig,
	input wire logic lowDuringConfigN,
	input wire logic ioActive,
	input wire logic gsrActive,
	input wire logic modeMiddleOe,
	input wire cil_pkg::cil_wr_s cfgWr
);
	import cil_pkg::*;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// two sync flops plus the output register
	property p_progInit;
		!programReqN [*6] |-> initOe;
	endproperty
	a_progInit: assert property (p_progInit) else $error("init not pulled by program");
	property p_doneFirst;
		$fell(doneOe) |-> !ioActive && gsrActive;
	endproperty
	a_doneFirst: assert property (p_doneFirst) else $error("done not first");
	property p_ioNext;
		$rose(ioActive) |-> !doneOe && gsrActive;
	endproperty
	a_ioNext: assert property (p_ioNext) else $error("io active out of order");
	property p_gsrLast;
		$fell(gsrActive) |-> ioActive && !doneOe;
	endproperty
	a_gsrLast: assert property (p_gsrLast) else $error("set/reset released early");
	property p_statusIo;
		highDuringConfig != ioActive && lowDuringConfigN == ioActive;
	endproperty
	a_statusIo: assert property (p_statusIo) else $error("status pins wrong");
	property p_doutHigh;
		cfgWr.strobe |-> dataOut;
	endproperty
	a_doutHigh: assert property (p_doutHigh) else $error("serial out low in frame");
	property p_middleOe;
		modeMiddleOe |-> ioActive;
	endproperty
	a_middleOe: assert property (p_middleOe) else $error("middle pad driven early");
	property p_slaveClk;
		(modeSel == MODE_SLAVE_SER) [*8] |-> !cfgClkOe;
	endproperty
	a_slaveClk: assert property (p_slaveClk) else $error("clock driven in slave");
	c_startup: cover property ($fell(gsrActive));
	c_restart: cover property ($rose(programReqN));
	c_frameBit: cover property (cfgWr.strobe);
endmodule // cil_props

bind cil_config_loader cil_props cil_props_inst (
	.mclk, .nrst, .programReqN, .modeSel, .initOe, .doneOe, .cfgClkOe, .dataOut,
	.highDuringConfig, .lowDuringConfigN, .ioActive, .gsrActive, .modeMiddleOe, .cfgWr
);

/* File: verification/cil_config_loader_tb.sv */
// self-checking bench for the configuration loader
`timescale 1ns/10ps
module cil_config_loader_tb;
	import cil_pkg::*;
	logic mclk, nrst, programReqN, extInitLow, cfgClkIn, dataIn, userWakeupClock;
	logic [2:0] modeSel, modePadPlaced;
	logic modeMiddleUserData, initOe, doneOe, modePullupEn, cfgClkOe, cfgClkOut, dataOut;
	logic [ADDR_W-1:0] promAddr;
	localparam int MWAIT_CYC = 8;
	logic highDuringConfig, lowDuringConfigN, ioActive, gsrActive;
	logic modeUpperUserPad, modeLowerUserPad, modeMiddleUserPad, modeMiddleOe;
	cil_opts_s opts;
	cil_wr_s cfgWr;
	int err_total, compares, strobes;
	time tDone, tIo, tGsr;
	wire initWire = !(initOe || extInitLow);
	wire doneWire = !doneOe;
	cil_config_loader #(.MASTER_WAIT_CYC(MWAIT_CYC)) cil_config_loader_inst (.mclk, .nrst,
		.programReqN, .initIn(initWire), .initOe, .doneIn(doneWire), .doneOe, .modeSel,
		.modePullupEn, .cfgClkIn, .cfgClkOut, .cfgClkOe, .dataIn, .dataOut, .promAddr,
		.highDuringConfig, .lowDuringConfigN, .opts, .userWakeupClock, .ioActive, .gsrActive,
		.modePadPlaced, .modeMiddleUserData, .modeUpperUserPad, .modeLowerUserPad,
		.modeMiddleUserPad, .modeMiddleOe, .cfgWr);
	cil_cfg_source cil_cfg_source_inst (.mclk, .initWire, .cfgClk(cfgClkIn), .cfgData(dataIn));
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	always @(negedge doneOe) tDone = $time;
	always @(posedge ioActive) tIo = $time;
	always @(negedge gsrActive) tGsr = $time;
	always @(posedge mclk) begin
		if (cfgWr.strobe === 1'h1) strobes <= strobes + 1;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic waitInit(input logic v, output int n);
		n = 0;
		while (initOe !== v && n < 3000) begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic t_reset();
		check({initOe, doneOe, highDuringConfig, lowDuringConfigN, modePullupEn, ioActive,
			gsrActive}, 7'h75);
	endtask
	task automatic t_initHold();
		int n;
		@(posedge mclk);
		nrst <= 1'h1;
		waitInit(1'h0, n);
		check(n >= POR_CYC + 2 * CLR_FRAMES && n < 3000, 1'h1);
		repeat (200) @(posedge mclk);
		check({initOe, lowDuringConfigN, strobes == 0}, 3'h1);
		extInitLow <= 1'h0;
	endtask
	task automatic t_load();
		int s0;
		s0 = strobes;
		cil_cfg_source_inst.send(1'h0);
		repeat (12) @(posedge mclk);
		check(strobes - s0, NUM_FRAMES * FRAME_DATA);
		check(tIo - tDone, 400);
		check(tGsr - tIo, 400);
		check({doneOe, gsrActive, modePullupEn, modeMiddleOe, modeMiddleUserPad}, 5'h03);
		modeMiddleUserData <= 1'h0;
		repeat (4) @(posedge mclk);
		check({modeMiddleUserPad, modeUpperUserPad, modeLowerUserPad}, 3'h3);
	endtask
	task automatic t_restart();
		int n;
		programReqN <= 1'h0;
		repeat (6) @(posedge mclk);
		check(initOe, 1'h1);
		repeat (100) @(posedge mclk);
		check(initOe, 1'h1);
		programReqN <= 1'h1;
		waitInit(1'h0, n);
		check(n >= CLR_FRAMES && n < 3000, 1'h1);
	endtask
	task automatic t_frameErr();
		int s0;
		s0 = strobes;
		cil_cfg_source_inst.send(1'h1);
		repeat (12) @(posedge mclk);
		check(initOe, 1'h1);
		check(strobes - s0, FRAME_DATA);
	endtask
	// data line idles low here, so the preamble hunt never ends and the clock keeps running
	task automatic t_master();
		int n;
		modeSel <= MODE_MPAR_DN;
		programReqN <= 1'h0;
		repeat (8) @(posedge mclk);
		programReqN <= 1'h1;
		n = 0;
		while (cfgClkOe !== 1'h1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check(n >= CLR_FRAMES + MWAIT_CYC && n < 3000, 1'h1);
		check(promAddr, ADDR_DN_START);
		n = 0;
		while (cfgClkOut !== 1'h1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check(n > 0 && n <= SLOW_HALF, 1'h1);
		repeat (2 * SLOW_HALF * 8 - SLOW_HALF) @(posedge mclk);
		check(promAddr, ADDR_DN_START - 18'h00001);
	endtask
	initial begin
		nrst = 1'h0;
		programReqN = 1'h1;
		extInitLow = 1'h1;
		modeSel = MODE_SLAVE_SER;
		opts = '{1'h0, 1'h0, DFLT_DONE_STG, DFLT_IO_STG, DFLT_GSR_STG};
		userWakeupClock = 1'h0;
		modePadPlaced = 3'h7;
		modeMiddleUserData = 1'h1;
		err_total = 0;
		compares = 0;
		repeat (19) @(posedge mclk);
		t_reset();
		t_initHold();
		t_load();
		t_restart();
		t_frameErr();
		t_master();
		print_verdict();
	end
	// whole run is near 4000 cycles; the limit allows about five times that
	initial begin
		#1000000;
		err_total++;
		print_verdict();
	end
endmodule // cil_config_loader_tb
